// ==== pudc_counter.sv ====
// pudc_counter: 4-bit presettable up/down counter, the device end.
// assumes count_clock, load and enable come from the driver end as levels
// sampled on clk_i; count_clock edges are found by comparing with its
// previous sample, so count_clock must be slower than clk_i.
// Notes on behaviour
// - four-bit count, driven out, counts both ways
// - low load copies preset inputs without clock
// - load overrides clock edges and enable
// - enable high holds the count
// - enable low steps once per rising clock
// - direction low increments, high decrements
// - terminal count at fifteen up, zero down
// - terminal count stays until count or direction change
// - terminal count ignores count enable
// - ripple clock follows clock at terminal, enabled
// - enable high suppresses ripple clock pulse
// - ripple clock rises with the clock
// - driver raises enable only while clock high
// - driver changes direction only when enable or clock high
// - terminal count never used as a clock
// - clock low phase covers ripple carry delay
// - synchronous cascade enables gate terminal counts
module pudc_counter
    import pudc_pkg::*;
#(
    parameter int WIDTH = PUDC_WIDTH
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    pudc_if.counter               pins
);

    // ************************************************************
    // count clock edge detection
    // ************************************************************
    logic                 cclk_q;
    logic                 cclk_rise;
    logic [WIDTH-1:0]     count_q;
    logic [WIDTH-1:0]     count_d;
    logic [WIDTH-1:0]     count_vis;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cclk_q <= 1'b0;
        else
            cclk_q <= pins.count_clock;
    end

    assign cclk_rise = pins.count_clock & ~cclk_q;

    // ************************************************************
    // count state
    // ************************************************************
    always_comb
    begin
        count_d = count_q;
        if (!pins.async_load_n)
            count_d = pins.preset_in;
        else if (!pins.count_en_n && cclk_rise)
        begin
            if (pins.dir_down == PUDC_DIR_UP)
                count_d = count_q + WIDTH'(PUDC_STEP);
            else
                count_d = count_q - WIDTH'(PUDC_STEP);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            count_q <= WIDTH'(PUDC_COUNT_RST);
        else
            count_q <= count_d;
    end

    // load is transparent: outputs show the presets in the same cycle
    assign count_vis = pins.async_load_n ? count_q : pins.preset_in;
    assign pins.count_out = count_vis;

    // ************************************************************
    // terminal count and ripple clock
    // ************************************************************
    // decoded from count and direction only, so it tracks either change
    assign pins.terminal_count =
        ((pins.dir_down == PUDC_DIR_UP)   && (count_vis == WIDTH'(PUDC_COUNT_MAX))) ||
        ((pins.dir_down == PUDC_DIR_DOWN) && (count_vis == WIDTH'(PUDC_COUNT_MIN)));
    // low only during the low clock phase, high again as the clock rises
    assign pins.ripple_clock_n =
        ~(pins.terminal_count & ~pins.count_en_n & ~pins.count_clock);

endmodule

// ==== pudc_driver.sv ====
// pudc_driver: driving logic for the counter; makes count_clock by division
// and applies user load, enable and direction requests at safe clock phases.
// assumes one clk_i shared with the counter end.
module pudc_driver
    import pudc_pkg::*;
#(
    parameter int WIDTH = PUDC_WIDTH,
    parameter int DIV   = PUDC_CLK_DIV
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             load_req_i,
    input  wire logic [WIDTH-1:0] load_val_i,
    input  wire logic             count_en_i,
    input  wire logic             dir_down_i,
    output logic [WIDTH-1:0]      count_o,
    output logic                  terminal_o,
    output logic                  carry_o,
    pudc_if.driver                pins
);

    // ************************************************************
    // count clock divider
    // ************************************************************
    localparam int HALF = DIV / 2;
    logic [15:0]          div_q;
    logic                 cclk_q;
    logic                 en_n_q;
    logic                 dir_q;
    logic                 load_n_q;
    logic [WIDTH-1:0]     preset_q;
    logic                 rc_q;
    pudc_state_t          state_q;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            div_q  <= 16'h0000;
            cclk_q <= 1'b0;
        end
        else if (div_q == 16'(HALF - 1))
        begin
            div_q  <= 16'h0000;
            cclk_q <= ~cclk_q;
        end
        else
            div_q <= div_q + 16'h0001;
    end

    // ************************************************************
    // enable raised only while the clock is high, lowered at any time; direction moved while disabled or clock high
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            en_n_q <= 1'b1;
            dir_q  <= PUDC_DIR_UP;
        end
        else
        begin
            if (!count_en_i)
            begin
                if (cclk_q)
                    en_n_q <= 1'b1;
            end
            else
                en_n_q <= 1'b0;
            if ((en_n_q || cclk_q) && dir_q != dir_down_i)
                dir_q <= dir_down_i;
        end
    end

    // ************************************************************
    // load sequencing
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q  <= PUDC_ST_IDLE;
            load_n_q <= 1'b1;
            preset_q <= WIDTH'(PUDC_COUNT_RST);
        end
        else
        begin
            case (state_q)
                PUDC_ST_IDLE:
                begin
                    if (load_req_i)
                    begin
                        preset_q <= load_val_i;
                        load_n_q <= 1'b0;
                        state_q  <= PUDC_ST_LOAD;
                    end
                end
                PUDC_ST_LOAD:
                begin
                    load_n_q <= 1'b1;
                    state_q  <= PUDC_ST_COUNT;
                end
                PUDC_ST_COUNT:
                    state_q <= PUDC_ST_IDLE;
                default:
                    state_q <= PUDC_ST_IDLE;
            endcase
        end
    end

    assign pins.count_clock  = cclk_q;
    assign pins.async_load_n = load_n_q;
    assign pins.count_en_n   = en_n_q;
    assign pins.dir_down     = dir_q;
    assign pins.preset_in    = preset_q;

    // ************************************************************
    // returned state, registered; terminal count only sampled
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            count_o    <= WIDTH'(PUDC_COUNT_RST);
            terminal_o <= 1'b0;
            rc_q       <= 1'b1;
            carry_o    <= 1'b0;
        end
        else
        begin
            count_o    <= pins.count_out;
            terminal_o <= pins.terminal_count;
            rc_q       <= pins.ripple_clock_n;
            carry_o    <= rc_q & ~pins.ripple_clock_n;
        end
    end

endmodule

// ==== pudc_if.sv ====
// pudc_if: the pins between the counter and the logic that drives it.
// assumes every pin is a plain level sampled on clk_i.
interface pudc_if;
    logic                 count_clock;
    logic                 async_load_n;
    logic                 count_en_n;
    logic                 dir_down;
    logic [3:0]           preset_in;
    logic [3:0]           count_out;
    logic                 terminal_count;
    logic                 ripple_clock_n;

    modport counter
    (
        input  count_clock,
        input  async_load_n,
        input  count_en_n,
        input  dir_down,
        input  preset_in,
        output count_out,
        output terminal_count,
        output ripple_clock_n
    );

    modport driver
    (
        output count_clock,
        output async_load_n,
        output count_en_n,
        output dir_down,
        output preset_in,
        input  count_out,
        input  terminal_count,
        input  ripple_clock_n
    );
endinterface

// ==== pudc_monitor.sv ====
// pudc_monitor: timing relations on the pins between counter and driver.
// assumes pins are sampled on clk_i and reset is rst_b_i, active low.
module pudc_monitor
    import pudc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       count_clock,
    input  wire logic       async_load_n,
    input  wire logic       count_en_n,
    input  wire logic       dir_down,
    input  wire logic [3:0] preset_in,
    input  wire logic [3:0] count_out,
    input  wire logic       terminal_count,
    input  wire logic       ripple_clock_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_load_shows;
        !async_load_n |-> count_out == preset_in;
    endproperty
    a_load_shows: assert property (p_load_shows)
        else $error("count does not show preset during load");
    property p_load_wins;
        !async_load_n |=> !async_load_n || count_out == $past(preset_in);
    endproperty
    a_load_wins: assert property (p_load_wins)
        else $error("count moved away from loaded value");
    property p_hold;
        async_load_n && count_en_n |=> !async_load_n || $stable(count_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count changed while disabled");
    property p_step;
        async_load_n && !count_en_n && count_clock && !$past(count_clock) |=>
            !async_load_n || count_out == ($past(dir_down) ?
            $past(count_out) - 4'h1 : $past(count_out) + 4'h1);
    endproperty
    a_step: assert property (p_step)
        else $error("count step wrong");
    property p_terminal;
        terminal_count == (dir_down ? count_out == PUDC_COUNT_MIN
                                    : count_out == PUDC_COUNT_MAX);
    endproperty
    a_terminal: assert property (p_terminal)
        else $error("terminal count wrong");
    property p_tc_stays;
        terminal_count ##1 ($stable(count_out) && $stable(dir_down)) |-> terminal_count;
    endproperty
    a_tc_stays: assert property (p_tc_stays)
        else $error("terminal count dropped without cause");
    property p_ripple;
        ripple_clock_n == !(terminal_count && !count_en_n && !count_clock);
    endproperty
    a_ripple: assert property (p_ripple)
        else $error("ripple clock wrong");
    property p_ripple_off;
        count_en_n |-> ripple_clock_n;
    endproperty
    a_ripple_off: assert property (p_ripple_off)
        else $error("ripple pulse while disabled");
    property p_ripple_rise;
        $rose(count_clock) |-> ripple_clock_n;
    endproperty
    a_ripple_rise: assert property (p_ripple_rise)
        else $error("ripple clock low while clock high");
    property p_en_rise;
        $rose(count_en_n) |-> $past(count_clock);
    endproperty
    a_en_rise: assert property (p_en_rise)
        else $error("count enable pin rose while count clock low");
    property p_dir_change;
        $changed(dir_down) |-> $past(count_en_n) || $past(count_clock);
    endproperty
    a_dir_change: assert property (p_dir_change)
        else $error("direction changed while enabled in clock low phase");
endmodule

// ==== pudc_pkg.sv ====
// pudc_pkg: shared widths, reset values and direction codes for the
// presettable up/down counter and its driving logic.
// assumes both ends run on one 10 MHz clock, clk_i.
package pudc_pkg;

    // ************************************************************
    // widths and values
    // ************************************************************
    localparam int          PUDC_WIDTH      = 4;
    localparam logic [3:0]  PUDC_COUNT_RST  = 4'h0;
    localparam logic [3:0]  PUDC_COUNT_MAX  = 4'hf;
    localparam logic [3:0]  PUDC_COUNT_MIN  = 4'h0;
    localparam logic [3:0]  PUDC_STEP       = 4'h1;
    localparam logic        PUDC_DIR_UP     = 1'b0;
    localparam logic        PUDC_DIR_DOWN   = 1'b1;
    localparam int          PUDC_CLK_HZ     = 10000000;
    // the count clock is the system clock divided by this; even, at least 2
    localparam int          PUDC_CLK_DIV    = 2;

    typedef enum logic [1:0]
    {
        PUDC_ST_IDLE  = 2'b00,
        PUDC_ST_LOAD  = 2'b01,
        PUDC_ST_COUNT = 2'b10
    } pudc_state_t;

endpackage

// ==== pudc_tb.sv ====
// pudc_tb: drives the driver end at random and checks the wire against
// a reference count. assumes one 10 MHz clock shared by both ends.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // harness
    // ************************************************************
    logic       clk_i = 0, rst_b_i = 0, load_req_i = 0, count_en_i = 0, dir_down_i = 0;
    logic [3:0] load_val_i = 4'h0;
    logic [3:0] count_o, exp_q, cur;
    logic       terminal_o, clk_prev_q, carry_o, rc_prev_q, rc_exp;
    logic       exp_tc_q, exp_carry_q;
    logic [3:0] exp_cnt_q, vis;
    int         fails = 0, samples_checked = 0;
    integer     seed = 62;

    always #50 clk_i = ~clk_i;
    pudc_if pins_if();
    pudc_counter pudc_counter_inst(.clk_i(clk_i), .rst_b_i(rst_b_i), .pins(pins_if.counter));
    pudc_driver pudc_driver_inst(.clk_i(clk_i), .rst_b_i(rst_b_i), .load_req_i(load_req_i),
        .load_val_i(load_val_i), .count_en_i(count_en_i), .dir_down_i(dir_down_i),
        .count_o(count_o), .terminal_o(terminal_o), .carry_o(carry_o), .pins(pins_if.driver));
    pudc_monitor pudc_monitor_inst(.clk_i(clk_i), .rst_b_i(rst_b_i),
        .count_clock(pins_if.count_clock), .async_load_n(pins_if.async_load_n),
        .count_en_n(pins_if.count_en_n), .dir_down(pins_if.dir_down),
        .preset_in(pins_if.preset_in), .count_out(pins_if.count_out),
        .terminal_count(pins_if.terminal_count), .ripple_clock_n(pins_if.ripple_clock_n));

    function automatic logic tc_of(logic [3:0] v, logic d);
        return d ? (v == 4'h0) : (v == 4'hf);
    endfunction
    task automatic check(logic [3:0] got, logic [3:0] want);
        samples_checked++;
        if (got !== want)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ************************************************************
    // reference count and checks, read late in the low clock phase
    // ************************************************************
    // what the wire should show now, before this edge's updates land
    assign vis    = pins_if.async_load_n ? exp_q : pins_if.preset_in;
    assign rc_exp = !(tc_of(vis, pins_if.dir_down) && !pins_if.count_en_n
                      && !pins_if.count_clock);
    always @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            {exp_q, clk_prev_q} <= 5'h00;
            {exp_cnt_q, exp_tc_q, exp_carry_q} <= 6'h00;
            rc_prev_q <= 1'b1;
        end
        else
        begin
            clk_prev_q  <= pins_if.count_clock;
            exp_cnt_q   <= vis;
            exp_tc_q    <= tc_of(vis, pins_if.dir_down);
            rc_prev_q   <= rc_exp;
            exp_carry_q <= rc_prev_q & ~rc_exp;
            if (!pins_if.async_load_n)
                exp_q <= pins_if.preset_in;
            else if (!pins_if.count_en_n && pins_if.count_clock && !clk_prev_q)
                exp_q <= pins_if.dir_down ? exp_q - 4'h1 : exp_q + 4'h1;
        end
    always
    begin
        @(negedge clk_i);
        #40;
        cur = pins_if.async_load_n ? exp_q : pins_if.preset_in;
        if (rst_b_i)
        begin
            check(pins_if.count_out, cur);
            check({3'h0, pins_if.terminal_count}, {3'h0, tc_of(cur, pins_if.dir_down)});
            check({3'h0, pins_if.ripple_clock_n}, {3'h0, !(tc_of(cur, pins_if.dir_down)
                && !pins_if.count_en_n && !pins_if.count_clock)});
            check(count_o, exp_cnt_q);
            check({3'h0, terminal_o}, {3'h0, exp_tc_q});
            check({3'h0, carry_o}, {3'h0, exp_carry_q});
        end
    end
    // ************************************************************
    // stimulus
    // ************************************************************
    task automatic load(logic [3:0] v, logic en = 1'b0);
        count_en_i = en;
        @(negedge clk_i);
        load_req_i = 1;
        load_val_i = v;
        @(negedge clk_i);
        load_req_i = 0;
        repeat (2) @(negedge clk_i);
        check(count_o, v);
    endtask
    initial
    begin
        repeat (3) @(negedge clk_i);
        rst_b_i = 1;
        for (int i = 0; i < 16; i++)
            load(i[3:0]);
        // wrap both ways from the end values
        for (int d = 0; d < 2; d++)
        begin
            load(d ? 4'h0 : 4'hf);
            dir_down_i = d[0];
            count_en_i = 1;
            repeat (12) @(negedge clk_i);
        end
        repeat (600)
        begin
            @(negedge clk_i);
            // a load sets the enable itself, so the two never share a time step
            if (($random(seed) & 15) == 0)
                load(4'($random(seed)), 1'($random(seed)));
            else
            begin
                count_en_i = 1'($random(seed));
                dir_down_i = 1'($random(seed));
            end
        end
        print_verdict;
    end
    initial
    begin
        #(100 * 5000);
        fails++;
        print_verdict;
    end
endmodule
